// file: hw/gw_params.svh
// timing, offsets and code constants for the position head gateway
`ifndef GW_PARAMS_SVH
`define GW_PARAMS_SVH
`define CLK_HZ 200000000
`define BAUD_LO 500000
`define BAUD_HI 2000000
`define WARN_HOLD_S 60
`define IDLE_LIMIT_MS 500
`define FLASH_MS 250
`define MS_PER_S 1000
`define POLL_TIMEOUT 16'h03e8
`define RESP_DELAY 8'h10
`define FRAME_BITS 8'h40
`define BYTES_ONE 4'h4
`define BYTES_TWO 4'h8
`define ERR_SELECTOR 4'h1
`define ERR_HEAD_ADDR 4'h2
`define WARN_NO_REPLY 4'h8
`define WARN_HEAD_ERR 4'h9
`define WARN_FIRST 4'h8
`define SEL_LAST_VALID 4'h3
`define OFF_CTRL 5'h00
`define OFF_HEAD0 5'h04
`define OFF_HEAD1 5'h08
`define OFF_IMG_LO 5'h0c
`define OFF_IMG_HI 5'h10
`define OFF_STATUS 5'h14
`define CTRL_RESET 32'h0000_0000
`define HEAD_RESET 32'h0000_0000
`define CTRL_BUS_RESET 5'h08
`define CTRL_POWER 5'h09
`define CTRL_LINK_OK 5'h0a
`define CTRL_OUT_OFF 5'h0b
`define CTRL_RUN 5'h0c
`define HEAD_ERR 5'h13
`define HEAD_OFF_RAIL 5'h14
`define HEAD_DIRTY 5'h15
`define HEAD_PRESENT 5'h16
`endif

// file: hw/gw_pkg.sv
// shared types and decode functions for the position head gateway
`include "gw_params.svh"
package gw_pkg;
  typedef logic [18:0] pos_t;
  typedef logic [1:0] head_addr_t;
  typedef logic [3:0] code_t;
  typedef enum logic [1:0] {
    POLL_IDLE = 2'b00,
    POLL_SEND = 2'b01,
    POLL_WAIT = 2'b10,
    POLL_HALT = 2'b11
  } poll_state_t;

  // selector position decodes
  function automatic logic sel_valid(input code_t sel);
    return sel <= `SEL_LAST_VALID;
  endfunction
  function automatic logic sel_two_heads(input code_t sel);
    return sel[0];
  endfunction
  function automatic logic sel_gray(input code_t sel);
    return ~sel[1];
  endfunction
  // clock cycles per fieldbus bit
  function automatic logic [15:0] bit_cycles(input logic fast);
    return fast ? 16'(`CLK_HZ / `BAUD_HI) : 16'(`CLK_HZ / `BAUD_LO);
  endfunction
endpackage

// file: hw/gw_link_if.sv
// link between the gateway and the fieldbus master with its heads
interface gw_link_if;
  logic poll_req;
  logic [1:0] poll_addr;
  logic poll_diag;
  logic resp_valid;
  logic [1:0] resp_addr;
  logic [18:0] resp_pos;
  logic resp_err;
  logic resp_off_rail;
  logic resp_dirty;
  logic [7:0] act_byte;
  logic xchg;
  logic bus_reset;
  logic bus_power;
  logic in_link_ok;
  logic out_off;
  logic [63:0] in_image;
  logic [3:0] in_bytes;
  logic rate_fast;
  modport gateway (
    output poll_req, poll_addr, poll_diag, in_image, in_bytes, rate_fast,
    input resp_valid, resp_addr, resp_pos, resp_err, resp_off_rail,
    input resp_dirty, act_byte, xchg, bus_reset, bus_power, in_link_ok,
    input out_off
  );
  modport master (
    input poll_req, poll_addr, poll_diag, in_image, in_bytes, rate_fast,
    output resp_valid, resp_addr, resp_pos, resp_err, resp_off_rail,
    output resp_dirty, act_byte, xchg, bus_reset, bus_power, in_link_ok,
    output out_off
  );
endinterface

// file: hw/code_conv.sv
// binary to gray position converter, bypassed in binary mode
module code_conv (
  input wire logic [18:0] bin,
  input wire logic gray_en,
  output logic [18:0] code
);
  // gray code is the value xor itself shifted right by one
  assign code = gray_en ? (bin ^ {1'b0, bin[18:1]}) : bin;
endmodule // code_conv

// file: hw/gw_gateway.sv
// gateway end: polls heads, builds the input image, drives indicators
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`include "gw_params.svh"
module gw_gateway import gw_pkg::*; #(
  parameter longint WARN_CYCLES = longint'(`WARN_HOLD_S) * `CLK_HZ,
  parameter int IDLE_CYCLES = `IDLE_LIMIT_MS * (`CLK_HZ / `MS_PER_S),
  parameter int FLASH_CYCLES = `FLASH_MS * (`CLK_HZ / `MS_PER_S)
) (
  input wire logic clk,
  input wire logic rst_b,
  gw_link_if.gateway link,
  input wire logic [3:0] head_count_code_selector,
  input wire logic [3:0] spare_selector,
  input wire logic rate_fast_sel,
  output logic status_green,
  output logic status_red,
  output logic [3:0] id_code_indicators,
  output logic bus_state_green,
  output logic bus_state_red,
  output logic bus_active_indicator,
  output logic bus_power_indicator,
  output logic remote_check_indicator,
  output logic outgoing_off_indicator
);
  poll_state_t state_reg;
  logic [1:0] addr_reg;
  logic [15:0] wait_cnt_reg;
  logic [31:0] slot_reg [2];
  logic [3:0] fatal_reg;
  logic [3:0] warn_reg;
  logic [33:0] warn_cnt_reg;
  logic [26:0] idle_cnt_reg;
  logic [25:0] flash_cnt_reg;
  logic flash_reg;
  logic seen_reg;
  logic poll_req_reg;
  logic [63:0] image_reg;
  logic [3:0] bytes_reg;
  logic rate_reg;
  logic [18:0] pos_code;
  logic two_heads;
  logic gray_mode;
  logic cfg_ok;
  logic got_resp;
  logic bad_addr;
  logic timed_out;
  logic idle_long;

  assign two_heads = sel_two_heads(head_count_code_selector);
  assign gray_mode = sel_gray(head_count_code_selector);
  // reserved positions and a nonzero spare selector stop normal work
  assign cfg_ok = sel_valid(head_count_code_selector) &
                  (spare_selector == 4'h0);
  assign got_resp = (state_reg == POLL_WAIT) & link.resp_valid &
                    (link.resp_addr == addr_reg);
  assign bad_addr = (state_reg == POLL_WAIT) & link.resp_valid &
                    (link.resp_addr != addr_reg);
  assign timed_out = (state_reg == POLL_WAIT) & ~link.resp_valid &
                     (wait_cnt_reg == `POLL_TIMEOUT);
  assign idle_long = idle_cnt_reg == 27'(IDLE_CYCLES);

  // only the position passes through the converter; the error and status bits bypass it
  code_conv conv (
    .bin(link.resp_pos),
    .gray_en(gray_mode),
    .code(pos_code)
  );

  // polling sequencer, free running and unaware of fieldbus cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= POLL_IDLE;
      addr_reg <= 2'h0;
      poll_req_reg <= 1'b0;
      wait_cnt_reg <= 16'h0;
    end else begin
      poll_req_reg <= 1'b0;
      case (state_reg)
        POLL_IDLE: begin
          if (!cfg_ok || fatal_reg != 4'h0) begin
            state_reg <= POLL_HALT;
          end else begin
            poll_req_reg <= 1'b1;
            wait_cnt_reg <= 16'h0;
            state_reg <= POLL_SEND;
          end
        end
        POLL_SEND: begin
          state_reg <= POLL_WAIT;
        end
        POLL_WAIT: begin
          wait_cnt_reg <= wait_cnt_reg + 16'h1;
          if (got_resp || bad_addr || timed_out) begin
            // alternate heads only when two are configured
            addr_reg <= two_heads ? addr_reg + 2'h1 : 2'h0;
            if (two_heads && addr_reg == 2'h1) begin
              addr_reg <= 2'h0;
            end
            state_reg <= POLL_IDLE;
          end
        end
        POLL_HALT: begin
          if (cfg_ok && fatal_reg == 4'h0) begin
            state_reg <= POLL_IDLE;
          end
        end
        default: begin
          state_reg <= POLL_IDLE;
        end
      endcase
    end
  end

  // latest valid answer of each head, in the response word layout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slot_reg[0] <= 32'h0;
      slot_reg[1] <= 32'h0;
    end else begin
      if (got_resp && !link.resp_addr[1]) begin
        slot_reg[link.resp_addr[0]] <= {pos_code[15:8], 5'h00,
          pos_code[18:16], 3'h0, link.resp_dirty, link.resp_err,
          link.resp_off_rail, link.resp_addr, pos_code[7:0]};
      end
    end
  end

  // input image toward the master, sized by the head count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      image_reg <= 64'h0;
      bytes_reg <= `BYTES_ONE;
      rate_reg <= 1'b0;
    end else begin
      image_reg <= {two_heads ? slot_reg[1] : 32'h0, slot_reg[0]};
      bytes_reg <= two_heads ? `BYTES_TWO : `BYTES_ONE;
      rate_reg <= rate_fast_sel;
    end
  end

  // fatal errors latch until reset; only rst_b clears them
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fatal_reg <= 4'h0;
    end else if (fatal_reg == 4'h0) begin
      if (!cfg_ok) begin
        fatal_reg <= `ERR_SELECTOR;
      end else if (bad_addr) begin
        fatal_reg <= `ERR_HEAD_ADDR;
      end
    end
  end

  // warnings show for one minute; a new one restarts the hold
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      warn_reg <= 4'h0;
      warn_cnt_reg <= 34'h0;
    end else begin
      if (timed_out || (got_resp && link.resp_err)) begin
        warn_reg <= timed_out ? `WARN_NO_REPLY : `WARN_HEAD_ERR;
        warn_cnt_reg <= 34'h0;
      end else if (warn_reg >= `WARN_FIRST) begin
        warn_cnt_reg <= warn_cnt_reg + 34'h1;
        if (warn_cnt_reg == 34'(WARN_CYCLES - 1)) begin
          warn_reg <= 4'h0;
        end
      end
    end
  end

  // head status and id indicators
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seen_reg <= 1'b0;
      status_green <= 1'b0;
      status_red <= 1'b0;
      id_code_indicators <= 4'h0;
    end else begin
      if (got_resp) begin
        seen_reg <= 1'b1;
      end else if (timed_out) begin
        seen_reg <= 1'b0;
      end
      if (fatal_reg != 4'h0) begin
        status_red <= 1'b1;
        status_green <= 1'b0;
        id_code_indicators <= fatal_reg;
      end else if (warn_reg != 4'h0) begin
        status_red <= 1'b1;
        status_green <= 1'b0;
        id_code_indicators <= warn_reg;
      end else begin
        status_red <= 1'b0;
        status_green <= seen_reg;
        id_code_indicators <= 4'h1 << addr_reg;
      end
    end
  end

  // fieldbus idle timer and flash phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt_reg <= 27'h0;
      flash_cnt_reg <= 26'h0;
      flash_reg <= 1'b0;
    end else begin
      if (link.xchg || link.bus_reset) begin
        idle_cnt_reg <= 27'h0;
      end else if (!idle_long) begin
        idle_cnt_reg <= idle_cnt_reg + 27'h1;
      end
      if (flash_cnt_reg == 26'(FLASH_CYCLES - 1)) begin
        flash_cnt_reg <= 26'h0;
        flash_reg <= ~flash_reg;
      end else begin
        flash_cnt_reg <= flash_cnt_reg + 26'h1;
      end
    end
  end

  // fieldbus state and diagnostic indicators
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_green <= 1'b0;
      bus_state_red <= 1'b0;
      bus_active_indicator <= 1'b0;
      bus_power_indicator <= 1'b0;
      remote_check_indicator <= 1'b0;
      outgoing_off_indicator <= 1'b0;
    end else begin
      if (link.bus_reset) begin
        bus_state_red <= 1'b1;
        bus_state_green <= 1'b0;
      end else if (idle_long) begin
        bus_state_red <= flash_reg;
        bus_state_green <= ~flash_reg;
      end else begin
        bus_state_red <= 1'b0;
        bus_state_green <= 1'b1;
      end
      bus_active_indicator <= ~link.bus_reset & ~idle_long;
      bus_power_indicator <= link.bus_power;
      remote_check_indicator <= link.in_link_ok & ~link.bus_reset;
      outgoing_off_indicator <= link.out_off;
    end
  end

  // link drive; diagnostic request follows the activation byte bits
  assign link.poll_req = poll_req_reg;
  assign link.poll_addr = addr_reg;
  assign link.poll_diag = link.act_byte[{addr_reg, 1'b0}];
  assign link.in_image = image_reg;
  assign link.in_bytes = bytes_reg;
  assign link.rate_fast = rate_reg;
endmodule // gw_gateway

// file: hw/gw_master.sv
// master end: fieldbus master and head model, steered over avalon-mm
`include "gw_params.svh"
module gw_master import gw_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  gw_link_if.master link,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  logic [31:0] ctrl_reg;
  logic [31:0] head_reg [2];
  logic [63:0] img_reg;
  logic [15:0] xchg_cnt_reg;
  logic [15:0] bit_cnt_reg;
  logic [7:0] frame_bit_reg;
  logic xchg_reg;
  logic [7:0] delay_reg;
  logic pend_reg;
  logic [1:0] paddr_reg;
  logic resp_valid_reg;
  logic [1:0] resp_addr_reg;
  logic access;
  logic do_write;
  logic [31:0] hsel;

  assign access = avs_read | avs_write;
  assign do_write = avs_write & ~avs_waitrequest;

  // one wait state, then the access completes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= ~(access & avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `OFF_CTRL: avs_readdata <= ctrl_reg;
          `OFF_HEAD0: avs_readdata <= head_reg[0];
          `OFF_HEAD1: avs_readdata <= head_reg[1];
          `OFF_IMG_LO: avs_readdata <= img_reg[31:0];
          `OFF_IMG_HI: avs_readdata <= img_reg[63:32];
          `OFF_STATUS: avs_readdata <= {11'h0, link.rate_fast,
                                        link.in_bytes, xchg_cnt_reg};
          default: avs_readdata <= 32'h0;
        endcase
      end
    end
  end

  // software writable control and head model registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= `CTRL_RESET;
      head_reg[0] <= `HEAD_RESET;
      head_reg[1] <= `HEAD_RESET;
    end else if (do_write) begin
      case (avs_address)
        `OFF_CTRL: ctrl_reg <= avs_writedata;
        `OFF_HEAD0: head_reg[0] <= avs_writedata;
        `OFF_HEAD1: head_reg[1] <= avs_writedata;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // exchange cycles paced by the bit rate the gateway selects
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= 16'h0;
      frame_bit_reg <= 8'h0;
      xchg_reg <= 1'b0;
      xchg_cnt_reg <= 16'h0;
      img_reg <= 64'h0;
    end else begin
      xchg_reg <= 1'b0;
      if (!ctrl_reg[`CTRL_RUN] || ctrl_reg[`CTRL_BUS_RESET]) begin
        bit_cnt_reg <= 16'h0;
        frame_bit_reg <= 8'h0;
      end else if (bit_cnt_reg == bit_cycles(link.rate_fast) - 16'h1) begin
        bit_cnt_reg <= 16'h0;
        frame_bit_reg <= frame_bit_reg + 8'h1;
        if (frame_bit_reg == `FRAME_BITS - 8'h1) begin
          frame_bit_reg <= 8'h0;
          xchg_reg <= 1'b1;
          xchg_cnt_reg <= xchg_cnt_reg + 16'h1;
          img_reg <= link.in_image;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 16'h1;
      end
    end
  end

  // head model: a present head answers at the polled address
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
      delay_reg <= 8'h0;
      paddr_reg <= 2'h0;
      resp_valid_reg <= 1'b0;
      resp_addr_reg <= 2'h0;
    end else begin
      resp_valid_reg <= 1'b0;
      if (link.poll_req && !link.poll_addr[1] &&
          head_reg[link.poll_addr[0]][`HEAD_PRESENT]) begin
        pend_reg <= 1'b1;
        delay_reg <= 8'h0;
        paddr_reg <= link.poll_addr;
      end else if (pend_reg) begin
        delay_reg <= delay_reg + 8'h1;
        if (delay_reg == `RESP_DELAY) begin
          pend_reg <= 1'b0;
          resp_valid_reg <= 1'b1;
          resp_addr_reg <= paddr_reg;
        end
      end
    end
  end

  assign hsel = head_reg[resp_addr_reg[0]];
  assign link.resp_valid = resp_valid_reg;
  assign link.resp_addr = resp_addr_reg;
  assign link.resp_pos = hsel[18:0];
  assign link.resp_err = hsel[`HEAD_ERR];
  assign link.resp_off_rail = hsel[`HEAD_OFF_RAIL];
  assign link.resp_dirty = hsel[`HEAD_DIRTY];
  assign link.act_byte = ctrl_reg[7:0];
  assign link.xchg = xchg_reg;
  assign link.bus_reset = ctrl_reg[`CTRL_BUS_RESET];
  assign link.bus_power = ctrl_reg[`CTRL_POWER];
  assign link.in_link_ok = ctrl_reg[`CTRL_LINK_OK];
  assign link.out_off = ctrl_reg[`CTRL_OUT_OFF];
endmodule // gw_master

// file: sim/gw_asserts.sv
// protocol checker watching the link between gateway and master
module gw_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic poll_req,
  input wire logic [1:0] poll_addr,
  input wire logic poll_diag,
  input wire logic resp_valid,
  input wire logic [1:0] resp_addr,
  input wire logic [7:0] act_byte,
  input wire logic xchg,
  input wire logic bus_reset,
  input wire logic [63:0] in_image,
  input wire logic [3:0] in_bytes
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] last_addr_reg;
  logic seen_reg;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // remembers the address of the previous poll
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_addr_reg <= 2'h0;
      seen_reg <= 1'b0;
    end else if (poll_req) begin
      last_addr_reg <= poll_addr;
      seen_reg <= 1'b1;
    end
  end

  a_poll_pulse: assert property (poll_req |=> !poll_req)
    else $error("poll request held too long");
  a_addr_range: assert property (poll_req |-> poll_addr < 2'h2)
    else $error("poll address out of range");
  a_one_head: assert property (
    poll_req && in_bytes == 4'h4 |-> poll_addr == 2'h0)
    else $error("single head not polled at zero");
  a_round_robin: assert property (
    poll_req && in_bytes == 4'h8 && seen_reg |-> poll_addr != last_addr_reg)
    else $error("two head polls not alternating");
  a_bytes_legal: assert property (
    in_bytes inside {4'h0, 4'h4, 4'h8})
    else $error("input byte count illegal");
  a_slot_addr: assert property (
    resp_valid && resp_addr == 2'h1 && in_bytes == 4'h8
    |-> ##[1:3] in_image[41:40] == 2'h1)
    else $error("second slot address field wrong");
  a_zero_bits: assert property (
    in_image[15:13] == 3'h0 && in_image[23:19] == 5'h00 &&
    in_image[47:45] == 3'h0 && in_image[55:51] == 5'h00)
    else $error("reserved image bits not zero");
  a_poll_diag: assert property (
    poll_req && $stable(act_byte) |-> poll_diag == act_byte[{poll_addr, 1'b0}])
    else $error("diagnostic request bit wrong");
  a_reset_quiet: assert property (
    bus_reset && $past(bus_reset) |-> !xchg)
    else $error("exchange during bus reset");
  // a good answer is followed by one quiet cycle, then the next poll
  a_reply_gap: assert property (
    resp_valid && resp_addr == poll_addr |=> !poll_req ##1 poll_req)
    else $error("poll spacing after answer wrong");

  c_second_head: cover property (poll_req && poll_addr == 2'h1);
  c_answer: cover property (resp_valid && resp_addr == 2'h0);
  c_exchange: cover property (xchg);
endmodule // gw_asserts

// file: sim/testbench.sv
// self-checking bench joining gateway and master ends
`include "gw_params.svh"
module testbench import gw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, rate_sel, avs_read, avs_write, avs_waitrequest;
  logic [3:0] hsel, spare, id_code_indicators;
  logic status_green, status_red, bus_state_green, bus_state_red;
  logic bus_active_indicator, bus_power_indicator;
  logic remote_check_indicator, outgoing_off_indicator;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed;
  int miscompares = 0;
  int cmp_count = 0;

  gw_link_if link_i ();
  gw_gateway #(.WARN_CYCLES(200), .IDLE_CYCLES(300), .FLASH_CYCLES(20))
    gw_gateway_i (.clk(clk), .rst_b(rst_b), .link(link_i),
    .head_count_code_selector(hsel), .spare_selector(spare),
    .rate_fast_sel(rate_sel), .status_green(status_green),
    .status_red(status_red), .id_code_indicators(id_code_indicators),
    .bus_state_green(bus_state_green), .bus_state_red(bus_state_red),
    .bus_active_indicator(bus_active_indicator),
    .bus_power_indicator(bus_power_indicator),
    .remote_check_indicator(remote_check_indicator),
    .outgoing_off_indicator(outgoing_off_indicator));
  gw_master gw_master_i (.clk(clk), .rst_b(rst_b), .link(link_i),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  gw_asserts gw_asserts_i (.clk(clk), .rst_b(rst_b),
    .poll_req(link_i.poll_req), .poll_addr(link_i.poll_addr),
    .poll_diag(link_i.poll_diag), .resp_valid(link_i.resp_valid),
    .resp_addr(link_i.resp_addr), .act_byte(link_i.act_byte),
    .xchg(link_i.xchg), .bus_reset(link_i.bus_reset),
    .in_image(link_i.in_image), .in_bytes(link_i.in_bytes));

  // free running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected image slot for a good answer
  function automatic logic [31:0] slot(input pos_t p, input logic [1:0] a,
                                       input logic g);
    pos_t c;
    c = g ? p ^ (p >> 1) : p;
    return {c[15:8], 5'h00, c[18:16], 6'h00, a, c[7:0]};
  endfunction

  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input string nm, input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task av(input logic w, input logic [4:0] a, input logic [31:0] d,
          output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task reset_dut(input logic [3:0] s, input logic [3:0] sp);
    rst_b <= 1'b0;
    hsel <= s;
    spare <= sp;
    tick(5);
    rst_b <= 1'b1;
    tick(2);
  endtask
  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    tick(80000);
    miscompares++;
    print_verdict;
  end

  // main sequence
  initial begin
    logic [31:0] q;
    pos_t p0, p1;
    logic two, g;
    int gc, rc;
    rst_b = 1'b0;
    hsel = 4'h0;
    spare = 4'h0;
    rate_sel = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    seed = 32'he1b8;
    for (int i = 0; i < 4; i++) begin
      two = i[0];
      g = !i[1];
      rate_sel <= (i != 3);
      reset_dut(i[3:0], 4'h0);
      seed = lfsr(seed);
      p0 = seed[18:0];
      seed = lfsr(seed);
      p1 = seed[18:0];
      av(1'b1, `OFF_HEAD0, {9'h000, 1'b1, 3'h0, p0}, q);
      av(1'b1, `OFF_HEAD1, {9'h000, 1'b1, 3'h0, p1}, q);
      av(1'b1, `OFF_CTRL, 32'h0000_1600, q);
      // heads come up absent after reset: the first poll times out
      // and its no-reply warning must expire before green shows
      tick(1400);
      chk("in_bytes", link_i.in_bytes, two ? 4'h8 : 4'h4);
      chk("slot0", link_i.in_image[31:0], slot(p0, 2'h0, g));
      if (two)
        chk("slot1", link_i.in_image[63:32], slot(p1, 2'h1, g));
      else
        chk("id", id_code_indicators, 4'h1);
      chk("status_green", status_green, 1'b1);
      while (link_i.xchg !== 1'b1) begin
        tick(1);
      end
      tick(2);
      chk("bus_green", bus_state_green, 1'b1);
      chk("bus_active", bus_active_indicator, 1'b1);
      chk("power", bus_power_indicator, 1'b1);
      chk("remote", remote_check_indicator, 1'b1);
      av(1'b0, `OFF_STATUS, 32'h0, q);
      chk("status", q[20:16], {i != 3, two ? 4'h8 : 4'h4});
    end
    av(1'b0, 5'h18, 32'h0, q);
    chk("unmapped", q, 32'h0);
    // stop exchanges and watch the flashing
    av(1'b1, `OFF_CTRL, 32'h0000_0600, q);
    while (bus_state_red !== 1'b1) begin
      tick(1);
    end
    gc = 0;
    rc = 0;
    repeat (60) begin
      tick(1);
      gc += int'(bus_state_green === 1'b1);
      rc += int'(bus_state_red === 1'b1);
    end
    chk("flash", {gc > 0, rc > 0, gc + rc > 60}, 3'b110);
    av(1'b1, `OFF_CTRL, 32'h0000_0f00, q);
    tick(5);
    chk("bus_reset", {bus_state_red, bus_state_green}, 2'b10);
    chk("out_off", outgoing_off_indicator, 1'b1);
    chk("rc_reset", remote_check_indicator, 1'b0);
    // missing head, then head error: warnings that clear
    reset_dut(4'h0, 4'h0);
    av(1'b1, `OFF_CTRL, 32'h0000_1600, q);
    for (int k = 0; k < 2; k++) begin
      av(1'b1, `OFF_HEAD0, {9'h000, k[0], 2'h0, k[0], p0}, q);
      while (status_red !== 1'b1) begin
        tick(1);
      end
      chk("warn_id", id_code_indicators, k[0] ? 4'h9 : 4'h8);
      av(1'b1, `OFF_HEAD0, {9'h000, 1'b1, 3'h0, p0}, q);
      tick(150);
      chk("warn_hold", status_red, 1'b1);
      // a poll missed while the head was absent times out once more
      tick(k ? 150 : 1150);
      chk("warn_clear", {status_green, id_code_indicators}, 5'h11);
    end
    // reserved selector, then nonzero spare: latched error one
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      reset_dut(k ? 4'h0 : (seed[3:0] | 4'h4), k ? (seed[3:0] | 4'h1) : 4'h0);
      tick(400);
      chk("err_red", status_red, 1'b1);
      chk("err_id", id_code_indicators, 4'h1);
    end
    print_verdict;
  end
endmodule // testbench
